/* rtl/smc_pkg.sv */
// Constants, register map and carrier types for the meter converter control block.
// Assumes a 40 MHz master clock and an APB master with 32-bit data.
// How it works
// - Comb filter counters held clear while filter_run is 0, run while 1.
// - Writing modulator_enable to 1 drives the modulator start output high.
// - Sample clock is master clock over 25 when select bit 4 set, else 50.
// - Output rate codes 000..110 give 125..8000 samples; code 111 also 8000.
// - Every N samples a new 15-bit signed result and conversion event appear.
// - Autozero bit 0 routes high/low inputs; 1 puts low input on both sides.
// - Two-bit gain code drives front end: 2/3, 1, 2, 2 1/3.
// - Result clamped to plus or minus 15625.
// - Result is two's complement, sign in bit 14, sign-extended upward.
// - Each result spans the last 2N samples; first two after changes unsettled.
// - Amp1 chopper: 00 low, 01 high, 10 master/250, 11 master/500.
// - Amp2 chopper uses the same four codes from its own field.
// - Each amplifier has its own enable bit.
// - Follower bit shorts amp1 output to its negative input.
// - Function field picks voltage, resistance, capacitance or special mode.
// - Range codes 000..100 pick divider taps, 101 and 110 capacitance paths.
// - Short select codes 010..111 short the test pin; others no short.
// - Resistance source bit: 0 input reference, 1 output reference.
// - Hysteresis bit: 0 one sixth, 1 one third of supply span.
// - Pad connect bit 0 leaves the high voltage pad floating, 1 connects it.
package smc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h06;
    localparam logic [7:0] IDX_IRQ_ENABLES = 8'h07;
    localparam logic [7:0] IDX_RES_HIGH    = 8'h10;
    localparam logic [7:0] IDX_RES_MID     = 8'h11;
    localparam logic [7:0] IDX_RES_LOW     = 8'h12;
    localparam logic [7:0] IDX_CONV_CTRL   = 8'h13;
    localparam logic [7:0] IDX_SHORT_SEL   = 8'h28;
    localparam logic [7:0] IDX_FUNC_CFG    = 8'h29;
    localparam logic [7:0] IDX_INPUT_SEL   = 8'h2A;
    localparam logic [7:0] IDX_REF_SEL     = 8'h2B;
    localparam logic [7:0] IDX_GAIN_AZ     = 8'h2E;
    localparam logic [7:0] IDX_CHOP_SEL    = 8'h2F;
    localparam logic [7:0] IDX_AMP_CTRL    = 8'h30;

    // Reset value shared by every register
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions
    localparam int unsigned BIT_DONE_FLAG  = 4;
    localparam int unsigned BIT_CONV_IE    = 4;
    localparam int unsigned BIT_GLOBAL_IE  = 7;
    localparam int unsigned BIT_FILTER_RUN = 3;
    localparam int unsigned BIT_SCLK_SEL   = 4;
    localparam int unsigned BIT_MOD_EN     = 1;
    localparam int unsigned BIT_AUTOZERO   = 0;

    // Clock figures
    localparam int unsigned MCLK_HZ        = 40_000_000;
    localparam int unsigned SAMPLE_DIV_HI  = 25;
    localparam int unsigned SAMPLE_DIV_LO  = 50;
    localparam int unsigned RATE_BASE      = 125;
    localparam int unsigned RATE_MAX_SHIFT = 6;
    localparam int unsigned CHOP_DIV_FAST  = 250;
    localparam int unsigned CHOP_HALF_FAST = CHOP_DIV_FAST / 2;
    localparam logic signed [15:0] RES_LIMIT = 16'sd15625;

    // Front end controls carried to the analog network
    typedef struct packed {
        logic       mod_en;
        logic       autozero;
        logic [1:0] gain;
        logic       amp1_en;
        logic       amp2_en;
        logic       amp1_follower;
        logic [2:0] amp1_pos_sel;
        logic [1:0] func;
        logic [2:0] range;
        logic [2:0] short_sel;
        logic       res_src;
        logic       cap_hyst;
        logic       hv_pad_connect;
        logic [7:0] input_sel;
        logic [7:0] ref_sel;
    } smc_afe_t;

endpackage

/* rtl/smc_top.sv */
// Converter control and decimation back end with its APB register file.
// Assumes the modulator bit arrives asynchronously and the master clock is clk_i.
`timescale 1ns/10ps
`default_nettype none
module smc_top import smc_pkg::*; #(
    parameter int unsigned ADDR_W = 8
) (
    // Clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              ce_i,
    // APB slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Modulator and front end
    input  wire logic              mod_bit_i,
    output smc_afe_t               afe_o,
    output logic                   sample_strobe_o,
    output logic                   chop1_o,
    output logic                   chop2_o,
    // Interrupt request to the CPU
    output logic                   irq_o
);

    // Reset release through two flops
    logic rst_meta_q, rst_n_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Modulator bit synchroniser
    logic mod_meta_q, mod_sync_q;
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mod_meta_q <= 1'b0;
            mod_sync_q <= 1'b0;
        end else if (ce_i) begin
            mod_meta_q <= mod_bit_i;
            mod_sync_q <= mod_meta_q;
        end
    end

    // Register storage
    logic [7:0]  flags_q, flags_d, ien_q, ien_d, conv_q, conv_d;
    logic [7:0]  short_q, short_d, func_q, func_d, insel_q, insel_d;
    logic [7:0]  rsel_q, rsel_d, gaz_q, gaz_d, chop_q, chop_d, amp_q, amp_d;
    logic [23:0] res_q, res_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d, pslverr_q, pslverr_d;

    // Decoder: only whole-word aligned addresses map
    logic [7:0] idx;
    logic       aligned, hit, setup, wr;
    logic [7:0] rd_byte;
    logic       result_evt;
    assign idx     = 8'(paddr_i >> 2);
    assign aligned = (paddr_i[1:0] == 2'b00) && ((32'(paddr_i) >> 2) < 32'd256);
    assign setup   = psel_i && !penable_i;
    assign wr      = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;

    always_comb begin
        hit     = aligned;
        rd_byte = 8'h00;
        unique case (idx)
            IDX_IRQ_FLAGS:   rd_byte = flags_q;
            IDX_IRQ_ENABLES: rd_byte = ien_q;
            IDX_RES_HIGH:    rd_byte = res_q[23:16];
            IDX_RES_MID:     rd_byte = res_q[15:8];
            IDX_RES_LOW:     rd_byte = res_q[7:0];
            IDX_CONV_CTRL:   rd_byte = conv_q;
            IDX_SHORT_SEL:   rd_byte = short_q;
            IDX_FUNC_CFG:    rd_byte = func_q;
            IDX_INPUT_SEL:   rd_byte = insel_q;
            IDX_REF_SEL:     rd_byte = rsel_q;
            IDX_GAIN_AZ:     rd_byte = gaz_q;
            IDX_CHOP_SEL:    rd_byte = chop_q;
            IDX_AMP_CTRL:    rd_byte = amp_q;
            default:         hit     = 1'b0;
        endcase
    end

    // Bus answer: no wait states, data and error captured in the setup cycle
    always_comb begin
        pready_d  = setup;
        pslverr_d = setup ? !hit : 1'b0;
        prdata_d  = prdata_q;
        if (setup) begin
            prdata_d = (hit && !pwrite_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (ce_i) begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    // Software writes; result bytes are read only and ignore writes
    always_comb begin
        flags_d = flags_q;
        ien_d   = ien_q;
        conv_d  = conv_q;
        short_d = short_q;
        func_d  = func_q;
        insel_d = insel_q;
        rsel_d  = rsel_q;
        gaz_d   = gaz_q;
        chop_d  = chop_q;
        amp_d   = amp_q;
        if (wr) begin
            unique case (idx)
                IDX_IRQ_FLAGS:   flags_d = pwdata_i[7:0];
                IDX_IRQ_ENABLES: ien_d   = pwdata_i[7:0];
                IDX_CONV_CTRL:   conv_d  = pwdata_i[7:0];
                IDX_SHORT_SEL:   short_d = {5'b0_0000, pwdata_i[2:0]};
                IDX_FUNC_CFG:    func_d  = pwdata_i[7:0];
                IDX_INPUT_SEL:   insel_d = pwdata_i[7:0];
                IDX_REF_SEL:     rsel_d  = pwdata_i[7:0];
                IDX_GAIN_AZ:     gaz_d   = pwdata_i[7:0];
                IDX_CHOP_SEL:    chop_d  = pwdata_i[7:0];
                IDX_AMP_CTRL:    amp_d   = pwdata_i[7:0];
                default:         ;
            endcase
        end
        // A result landing with a clearing write still sets the flag
        if (result_evt) begin
            flags_d[BIT_DONE_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flags_q <= REG_RESET;
            ien_q   <= REG_RESET;
            conv_q  <= REG_RESET;
            short_q <= REG_RESET;
            func_q  <= REG_RESET;
            insel_q <= REG_RESET;
            rsel_q  <= REG_RESET;
            gaz_q   <= REG_RESET;
            chop_q  <= REG_RESET;
            amp_q   <= REG_RESET;
        end else if (ce_i) begin
            flags_q <= flags_d;
            ien_q   <= ien_d;
            conv_q  <= conv_d;
            short_q <= short_d;
            func_q  <= func_d;
            insel_q <= insel_d;
            rsel_q  <= rsel_d;
            gaz_q   <= gaz_d;
            chop_q  <= chop_d;
            amp_q   <= amp_d;
        end
    end

    // Sample clock divider
    logic [5:0] sdiv_q, sdiv_d;
    logic [5:0] sdiv_top;
    logic       stick_q, stick_d, run;
    assign run      = conv_q[BIT_FILTER_RUN];
    assign sdiv_top = conv_q[BIT_SCLK_SEL] ? 6'(SAMPLE_DIV_HI - 1)
                                           : 6'(SAMPLE_DIV_LO - 1);

    always_comb begin
        sdiv_d  = sdiv_q;
        stick_d = 1'b0;
        if (!run) begin
            sdiv_d = 6'h00;
        end else if (sdiv_q >= sdiv_top) begin
            sdiv_d  = 6'h00;
            stick_d = 1'b1;
        end else begin
            sdiv_d = sdiv_q + 6'h01;
        end
    end

    // Decimation window: ones counted over N, result spans two windows
    logic [2:0]  rate;
    logic [2:0]  shift;
    logic [13:0] n_len;
    logic [13:0] wcnt_q, wcnt_d, ones_q, ones_d, prev_q, prev_d;
    logic        evt_q, evt_d;
    logic [13:0] ones_now;
    logic signed [16:0] diff;
    logic signed [23:0] scaled, shifted;
    logic signed [15:0] clamped;
    assign rate  = conv_q[2:0];
    assign shift = (rate == 3'b111) ? 3'(RATE_MAX_SHIFT) : rate;
    assign n_len = 14'(RATE_BASE << shift);
    assign ones_now = ones_q + {13'h0000, mod_sync_q};
    assign diff     = $signed({3'b000, prev_q}) + $signed({3'b000, ones_now})
                      - $signed({2'b00, n_len, 1'b0});
    assign scaled   = 24'(diff * 24'sd125);
    assign shifted  = scaled >>> (shift + 3'd1);

    // Saturation at full scale
    always_comb begin
        if (shifted > 24'(RES_LIMIT)) begin
            clamped = RES_LIMIT;
        end else if (shifted < -24'(RES_LIMIT)) begin
            clamped = -RES_LIMIT;
        end else begin
            clamped = 16'(shifted);
        end
    end

    always_comb begin
        wcnt_d = wcnt_q;
        ones_d = ones_q;
        prev_d = prev_q;
        evt_d  = 1'b0;
        res_d  = res_q;
        if (!run) begin
            wcnt_d = 14'h0000;
            ones_d = 14'h0000;
            prev_d = 14'h0000;
        end else if (stick_q) begin
            if (wcnt_q >= n_len - 14'h0001) begin
                wcnt_d = 14'h0000;
                ones_d = 14'h0000;
                prev_d = ones_now;
                evt_d  = 1'b1;
                res_d  = {{9{clamped[14]}}, clamped[14:0]};
            end else begin
                wcnt_d = wcnt_q + 14'h0001;
                ones_d = ones_now;
            end
        end
    end
    assign result_evt = evt_q;

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sdiv_q  <= 6'h00;
            stick_q <= 1'b0;
            wcnt_q  <= 14'h0000;
            ones_q  <= 14'h0000;
            prev_q  <= 14'h0000;
            evt_q   <= 1'b0;
            res_q   <= 24'h00_0000;
        end else if (ce_i) begin
            sdiv_q  <= sdiv_d;
            stick_q <= stick_d;
            wcnt_q  <= wcnt_d;
            ones_q  <= ones_d;
            prev_q  <= prev_d;
            evt_q   <= evt_d;
            res_q   <= res_d;
        end
    end

    // Chopper divider: one counter, two toggles give both rates
    logic [7:0] cdiv_q, cdiv_d;
    logic       ck250_q, ck250_d, ck500_q, ck500_d;
    always_comb begin
        cdiv_d  = (cdiv_q == 8'(CHOP_DIV_FAST - 1)) ? 8'h00 : cdiv_q + 8'h01;
        ck250_d = ck250_q;
        ck500_d = ck500_q;
        if (cdiv_q == 8'(CHOP_HALF_FAST - 1) || cdiv_q == 8'(CHOP_DIV_FAST - 1)) begin
            ck250_d = !ck250_q;
        end
        if (cdiv_q == 8'(CHOP_DIV_FAST - 1)) begin
            ck500_d = !ck500_q;
        end
    end

    // Chopper select per amplifier
    function automatic logic chop_pick(input logic [1:0] sel, input logic f, input logic s);
        unique case (sel)
            2'b00:   chop_pick = 1'b0;
            2'b01:   chop_pick = 1'b1;
            2'b10:   chop_pick = f;
            2'b11:   chop_pick = s;
        endcase
    endfunction

    // Front end controls, registered so each pin comes from a flop
    smc_afe_t afe_q, afe_d;
    logic     chop1_q, chop1_d, chop2_q, chop2_d, irq_q, irq_d, sstb_q;
    always_comb begin
        afe_d.mod_en         = gaz_q[BIT_MOD_EN];
        afe_d.autozero       = gaz_q[BIT_AUTOZERO];
        afe_d.gain           = gaz_q[3:2];
        afe_d.amp1_en        = amp_q[3];
        afe_d.amp2_en        = amp_q[4];
        afe_d.amp1_follower  = amp_q[5];
        afe_d.amp1_pos_sel   = amp_q[2:0];
        afe_d.func           = func_q[1:0];
        afe_d.range          = func_q[4:2];
        afe_d.short_sel      = (short_q[2:1] == 2'b00) ? 3'b000 : short_q[2:0];
        afe_d.res_src        = func_q[6];
        afe_d.cap_hyst       = func_q[5];
        afe_d.hv_pad_connect = func_q[7];
        afe_d.input_sel      = insel_q;
        afe_d.ref_sel        = rsel_q;
        chop1_d = chop_pick(chop_q[1:0], ck250_q, ck500_q);
        chop2_d = chop_pick(chop_q[3:2], ck250_q, ck500_q);
        irq_d   = flags_q[BIT_DONE_FLAG] && ien_q[BIT_CONV_IE] && ien_q[BIT_GLOBAL_IE];
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cdiv_q  <= 8'h00;
            ck250_q <= 1'b0;
            ck500_q <= 1'b0;
            afe_q   <= '0;
            chop1_q <= 1'b0;
            chop2_q <= 1'b0;
            irq_q   <= 1'b0;
            sstb_q  <= 1'b0;
        end else if (ce_i) begin
            cdiv_q  <= cdiv_d;
            ck250_q <= ck250_d;
            ck500_q <= ck500_d;
            afe_q   <= afe_d;
            chop1_q <= chop1_d;
            chop2_q <= chop2_d;
            irq_q   <= irq_d;
            sstb_q  <= stick_d;
        end
    end

    // Output pins
    assign prdata_o        = prdata_q;
    assign pready_o        = pready_q;
    assign pslverr_o       = pslverr_q;
    assign afe_o           = afe_q;
    assign sample_strobe_o = sstb_q;
    assign chop1_o         = chop1_q;
    assign chop2_o         = chop2_q;
    assign irq_o           = irq_q;

endmodule
`default_nettype wire

/* bench/smc_mod_model.sv */
// Behavioural modulator bitstream source for the converter back end.
// Assumes one bit per sample tick; the density input sets ones per eight ticks.
`timescale 1ns/10ps
`default_nettype none
module smc_mod_model (
    // Clock and sample tick
    input  wire logic       clk_i,
    input  wire logic       strobe_i,
    // Ones per eight samples, 0 to 8
    input  wire logic [3:0] ones_i,
    // Bitstream towards the converter
    output logic            bit_o
);
    logic [2:0] ph_q;

    initial ph_q = 3'h0;
    initial bit_o = 1'b0;

    // Moves only on a tick, so the bit stands for a whole sample period
    always @(posedge clk_i) begin
        if (strobe_i) begin
            ph_q  <= ph_q + 3'h1;
            bit_o <= ({1'b0, ph_q} < ones_i);
        end
    end
endmodule
`default_nettype wire

/* bench/smc_top_asserts.sv */
// Port checker for the converter control block, bound into the top module.
// Assumes clean APB transfers; shadows register writes to predict outputs.
`timescale 1ns/10ps
`default_nettype none
module smc_top_asserts import smc_pkg::*; #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic              clk_i,
    input wire logic              reset_n_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire smc_afe_t          afe_o,
    input wire logic              sample_strobe_o,
    input wire logic              chop1_o,
    input wire logic              irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    logic       wr;
    logic [7:0] ien_q, gain_q, chop_q, amp_q, func_q, short_q, conv_q;
    logic [8:0] quiet_q, gap_q, run_q;
    logic       seen_q, c1_q;

    assign wr = psel_i && penable_i && pwrite_i && pready_o && !pslverr_o;

    // Shadow registers and counters; quiet saturates so old writes stop mattering
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {ien_q, gain_q, chop_q, amp_q, func_q, short_q, conv_q} <= '0;
            {quiet_q, gap_q, run_q, seen_q, c1_q} <= '0;
        end else begin
            if (wr && paddr_i[7:2] == IDX_IRQ_ENABLES[5:0]) ien_q <= pwdata_i[7:0];
            if (wr && paddr_i[7:2] == IDX_GAIN_AZ[5:0]) gain_q <= pwdata_i[7:0];
            if (wr && paddr_i[7:2] == IDX_CHOP_SEL[5:0]) chop_q <= pwdata_i[7:0];
            if (wr && paddr_i[7:2] == IDX_AMP_CTRL[5:0]) amp_q <= pwdata_i[7:0];
            if (wr && paddr_i[7:2] == IDX_FUNC_CFG[5:0]) func_q <= pwdata_i[7:0];
            if (wr && paddr_i[7:2] == IDX_SHORT_SEL[5:0]) short_q <= pwdata_i[7:0];
            if (wr && paddr_i[7:2] == IDX_CONV_CTRL[5:0]) conv_q <= pwdata_i[7:0];
            quiet_q <= wr ? 9'h000 : quiet_q + {8'h00, ~&quiet_q};
            gap_q   <= sample_strobe_o ? 9'h001 : gap_q + {8'h00, ~&gap_q};
            seen_q  <= seen_q | sample_strobe_o;
            c1_q    <= chop1_o;
            run_q   <= (chop1_o != c1_q) ? 9'h001 : run_q + {8'h00, ~&run_q};
        end
    end

    AST_SETUP_ANSWER: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
        else $error("access answer not one cycle after setup");
    AST_MOD_EN: assert property (quiet_q > 9'h003 |-> afe_o.mod_en == gain_q[1])
        else $error("modulator enable differs from register");
    AST_AUTOZERO: assert property (quiet_q > 9'h003 |-> afe_o.autozero == gain_q[0])
        else $error("autozero differs from register");
    AST_GAIN: assert property (quiet_q > 9'h003 |-> afe_o.gain == gain_q[3:2])
        else $error("gain differs from register");
    AST_AMP: assert property (quiet_q > 9'h003 |->
        {afe_o.amp1_follower, afe_o.amp2_en, afe_o.amp1_en} == amp_q[5:3])
        else $error("amplifier controls differ from register");
    AST_FUNC: assert property (quiet_q > 9'h003 |->
        {afe_o.hv_pad_connect, afe_o.res_src, afe_o.cap_hyst, afe_o.range, afe_o.func} == func_q)
        else $error("network controls differ from register");
    AST_SHORT: assert property (quiet_q > 9'h003 |->
        afe_o.short_sel == ((short_q[2:1] == 2'b00) ? 3'h0 : short_q[2:0]))
        else $error("short select wrong");
    AST_SAMPLE_GAP: assert property (sample_strobe_o && seen_q && (&quiet_q) |->
        gap_q == (conv_q[4] ? 9'h019 : 9'h032))
        else $error("sample tick spacing wrong");
    AST_CHOP_STATIC: assert property (quiet_q > 9'h003 && !chop_q[1] |-> chop1_o == chop_q[0])
        else $error("static chopper level wrong");
    AST_CHOP_RUN: assert property ((chop1_o != c1_q) && (&quiet_q) && chop_q[1] |->
        run_q == (chop_q[0] ? 9'h0FA : 9'h07D))
        else $error("chopper half period wrong");
    AST_IRQ_MASK: assert property (quiet_q > 9'h003 && !(ien_q[4] && ien_q[7]) |-> !irq_o)
        else $error("interrupt while masked");

    COV_IRQ: cover property ($rose(irq_o));
    COV_ERR: cover property (pready_o && pslverr_o);
    COV_CHOP: cover property ((chop1_o != c1_q) && (&quiet_q) && chop_q[1]);
endmodule

bind smc_top smc_top_asserts #(.ADDR_W(ADDR_W)) u_asserts (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .afe_o, .sample_strobe_o, .chop1_o, .irq_o);
`default_nettype wire

/* bench/smc_top_test.sv */
// Self-checking bench for the converter control block over APB.
// Assumes a 40 MHz clock and a modulator model that sends only zeros.
`timescale 1ns/10ps
`default_nettype none
module smc_top_test import smc_pkg::*;;
    localparam logic [7:0] REGS [13] = '{IDX_IRQ_FLAGS, IDX_IRQ_ENABLES, IDX_RES_HIGH, IDX_RES_MID, IDX_RES_LOW,
        IDX_CONV_CTRL, IDX_SHORT_SEL, IDX_FUNC_CFG, IDX_INPUT_SEL, IDX_REF_SEL, IDX_GAIN_AZ, IDX_CHOP_SEL, IDX_AMP_CTRL};
    logic        clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o;
    logic        pready_o, pslverr_o, mod_bit_i, sample_strobe_o, chop1_o, chop2_o, irq_o;
    smc_afe_t    afe_o;
    int          mismatches = 0, n_compared = 0;

    always #12.5 clk_i = ~clk_i;

    smc_top DUT (.clk_i, .reset_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .mod_bit_i, .afe_o, .sample_strobe_o, .chop1_o, .chop2_o, .irq_o);
    smc_mod_model u_mod (.clk_i, .strobe_i(sample_strobe_o), .ones_i(4'h0), .bit_o(mod_bit_i));

    task automatic close_out();
        if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r, output logic e);
        @(posedge clk_i);
        psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= {24'h00_0000, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do @(posedge clk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r; logic e;
        apb(1'b1, {idx[5:0], 2'b00}, d, r, e);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp, input logic xerr);
        logic [31:0] r; logic e;
        apb(1'b0, a, 8'h00, r, e);
        check(nm, r, {24'h00_0000, exp});
        check(nm, {31'h0000_0000, e}, {31'h0000_0000, xerr});
    endtask

    // Hang guard: the full sequence needs about 22k cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        close_out();
    end

    initial begin
        int n, t1, t2;
        logic p1, p2;
        logic [7:0] f, a, g, x;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 13; i++) rdc("reset", {REGS[i][5:0], 2'b00}, 8'h00, 1'b0);
        rdc("unmapped", 8'h04, 8'h00, 1'b1);
        rdc("misaligned", 8'h19, 8'h00, 1'b1);
        // Result bytes ignore writes; short select keeps three bits, the rest all eight
        for (int i = 0; i < 13; i++) wr(REGS[i], 8'h5A);
        for (int i = 0; i < 13; i++)
            rdc("rw", {REGS[i][5:0], 2'b00}, (REGS[i] inside {IDX_RES_HIGH, IDX_RES_MID, IDX_RES_LOW}) ? 8'h00
                : (REGS[i] == IDX_SHORT_SEL) ? 8'h02 : 8'h5A, 1'b0);
        for (int i = 0; i < 13; i++) wr(REGS[i], 8'h00);
        for (int k = 0; k < 2; k++) begin
            f = k ? 8'h19 : 8'hE6; a = k ? 8'h07 : 8'h38; g = k ? 8'h00 : 8'h0F;
            wr(IDX_FUNC_CFG, f); wr(IDX_AMP_CTRL, a); wr(IDX_GAIN_AZ, g);
            repeat (4) @(posedge clk_i);
            check("afe", 32'({afe_o.hv_pad_connect, afe_o.res_src, afe_o.cap_hyst, afe_o.range, afe_o.func,
                afe_o.amp1_follower, afe_o.amp2_en, afe_o.amp1_en, afe_o.amp1_pos_sel, afe_o.gain, afe_o.mod_en,
                afe_o.autozero}), 32'({f, a[5:0], g[3:0]}));
        end
        for (int c = 0; c < 8; c++) begin
            wr(IDX_SHORT_SEL, 8'(c));
            repeat (4) @(posedge clk_i);
            check("short", 32'(afe_o.short_sel), (c < 2) ? 32'h0000_0000 : 32'(c));
        end
        // Each chopper gets every code; toggles counted over a 1000 cycle window
        for (int c = 0; c < 4; c++) begin
            x = 8'(c);
            wr(IDX_CHOP_SEL, {4'h0, x[1:0], ~x[1:0]});
            repeat (300) @(posedge clk_i);
            t1 = 0; t2 = 0; p1 = chop1_o; p2 = chop2_o;
            repeat (1000) begin
                @(posedge clk_i);
                t1 += int'(chop1_o !== p1); t2 += int'(chop2_o !== p2);
                p1 = chop1_o; p2 = chop2_o;
            end
            check("chop1", ~x[1] ? 32'(t1) : 32'(chop1_o), ~x[1] ? (~x[0] ? 32'd4 : 32'd8) : 32'(!x[0]));
            check("chop2", x[1] ? 32'(t2) : 32'(chop2_o), x[1] ? (x[0] ? 32'd4 : 32'd8) : 32'(x[0]));
        end
        // Conversion at rate 000, tick every 25 clocks: 3125 clocks a result; autozero on, so it is the offset
        wr(IDX_CHOP_SEL, 8'h00); wr(IDX_IRQ_ENABLES, 8'h90); wr(IDX_GAIN_AZ, 8'h03); wr(IDX_CONV_CTRL, 8'h18);
        n = 0;
        while (irq_o !== 1'b1 && n < 4000) begin @(posedge clk_i); n++; end
        check("first_result", 32'(n > 3100 && n < 3160), 32'h0000_0001);
        rdc("res_high", {IDX_RES_HIGH[5:0], 2'b00}, 8'hFF, 1'b0);
        rdc("res_mid", {IDX_RES_MID[5:0], 2'b00}, 8'hC2, 1'b0);
        rdc("res_low", {IDX_RES_LOW[5:0], 2'b00}, 8'hF7, 1'b0);
        rdc("flag", {IDX_IRQ_FLAGS[5:0], 2'b00}, 8'h10, 1'b0);
        wr(IDX_IRQ_FLAGS, 8'h00);
        repeat (3) @(posedge clk_i);
        check("irq_clear", 32'(irq_o), 32'h0000_0000);
        // Global enable off, autozero cleared: two results skipped, then the settled
        // one is again -15625, low byte F7, for an all-zero stream
        wr(IDX_IRQ_ENABLES, 8'h10); wr(IDX_GAIN_AZ, 8'h02);
        repeat (9500) @(posedge clk_i);
        check("irq_masked", 32'(irq_o), 32'h0000_0000);
        rdc("flag_masked", {IDX_IRQ_FLAGS[5:0], 2'b00}, 8'h10, 1'b0);
        rdc("res_settled", {IDX_RES_LOW[5:0], 2'b00}, 8'hF7, 1'b0);
        // Filter held in reset, slow sample clock: no new result, old one kept
        wr(IDX_CONV_CTRL, 8'h00); wr(IDX_IRQ_FLAGS, 8'h00);
        repeat (3300) @(posedge clk_i);
        rdc("flag_stopped", {IDX_IRQ_FLAGS[5:0], 2'b00}, 8'h00, 1'b0);
        rdc("res_kept", {IDX_RES_LOW[5:0], 2'b00}, 8'hF7, 1'b0);
        // Clock enable low freezes the chopper; three half periods would flip it
        wr(IDX_CHOP_SEL, 8'h02);
        repeat (2) @(posedge clk_i);
        ce_i <= 1'b0;
        @(posedge clk_i);
        p1 = chop1_o;
        repeat (375) @(posedge clk_i);
        check("ce_freeze", 32'(chop1_o), 32'(p1));
        ce_i <= 1'b1;
        close_out();
    end
endmodule
`default_nettype wire
